// [bench/fbpe_flash_model.sv]
// behavioural nor flash device answering the host controller
`timescale 1ns/1ps
module fbpe_flash_model
import fbpe_pkg::*;
#(
    parameter int BUSY_READS = 4, // status reads before done
    parameter int WIN_NS = 1000 // sector add window length
) (
    input wire fbpe_pkg::fbpe_pins_t pins,
    output logic [15:0] dq
);
    fbpe_cyc_t log[$]; // every write cycle seen
    logic busy = 0, sect = 0, tog = 0, cntNext = 0, aborted = 0;
    int reads = 0, skip = 0;
    realtime winT = 0;
    logic [15:0] rdv = 16'h0; // last value put on the bus
    logic [23:0] busyA = 24'h0; // sector being erased
    // window still open
    function automatic logic winOpen();
        return ($realtime - winT) < WIN_NS;
    endfunction
    // commands taken at write strobe rising edge
    always @(posedge pins.weN) begin
        if (pins.ceN === 1'b0 && pins.rstN === 1'b1) begin
            log.push_back({pins.addr, pins.dout});
            if (skip > 0) begin
                skip--;
            end
            else if (cntNext) begin
                cntNext = 0;
                if (pins.dout > 16'h001f) aborted = 1;
                else skip = pins.dout + 1;
            end
            // window adds sectors or drops erase
            else if (busy && sect && winOpen()) begin
                if (pins.dout == 16'h0030) begin
                    winT = $realtime;
                    busyA = pins.addr;
                end else begin
                    busy = 0;
                end
            end
            else if (!busy) begin
                case (pins.dout)
                    // abort state blocks new loads
                    16'h0025: if (!aborted) cntNext = 1;
                    16'h00f0: aborted = 0;
                    16'h0029, 16'h0010, 16'h0030: begin
                        busy = 1;
                        reads = 0;
                        sect = (pins.dout == 16'h0030);
                        winT = $realtime;
                        busyA = pins.addr;
                    end
                    default: ;
                endcase
            end
        end
    end
    always @(negedge pins.oeN) begin
        // during a sector erase other banks keep serving array data; program and chip erase answer status at every address
        if (pins.ceN === 1'b0 && busy &&
            (!sect || pins.addr[23:20] == busyA[23:20])) begin
            tog = ~tog;
            rdv = 16'h0;
            rdv[6] = tog;
            rdv[2] = tog;
            rdv[3] = !winOpen();
            if (!sect || !winOpen()) reads++;
            // back to array read when done
            if (reads >= BUSY_READS) busy = 0;
        end else begin
            rdv = pins.addr[15:0] ^ 16'h5a5a;
        end
    end
    always @(negedge pins.rstN) busy = 0;
    // released bus shows the inverse of the last value
    assign dq = (pins.oeN === 1'b0 && pins.ceN === 1'b0) ? rdv : ~rdv;
endmodule

// [bench/tb.sv]
// self-checking bench for the flash sequencer host
`timescale 1ns/1ps
`include "fbpe_params.svh"
module tb;
    import fbpe_pkg::*;
    localparam int WIN = 20; // short sector add window
    logic clk_sys = 0, srst = 1;
    fbpe_swreq_t swReq = '0;
    logic [31:0] swRdata, s;
    fbpe_pins_t pins;
    logic [15:0] dq, dqIn;
    logic [23:0] t, t2;
    logic [15:0] w[$];
    int n_fail = 0, n_compared = 0, cyc = 0, n, k;
    fbpe_cyc_t exp[$]; // expected write cycles
    // data bus seen by the host
    assign dqIn = pins.dqOe ? pins.dout : dq;
    fbpe_host #(.WIN_CYC(WIN)) uut (.clk_sys(clk_sys), .srst(srst),
        .swReq(swReq), .swRdata(swRdata), .flashPins(pins),
        .flashDqIn(dqIn));
    fbpe_flash_model #(.WIN_NS(WIN * 50)) flash (.pins(pins), .dq(dq));
    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chkReg(string nm, logic [31:0] e, logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chkCyc(fbpe_cyc_t e, fbpe_cyc_t g);
        n_compared++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected write expected %h seen %h", e, g);
        end
    endtask
    // compare write log with expectation, then clear both
    task automatic chkSeq();
        chkReg("write count", exp.size(), flash.log.size());
        foreach (exp[i]) chkCyc(exp[i], flash.log[i]);
        exp.delete();
        flash.log.delete();
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        swReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        swReq.wr <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        swReq <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        swReq.rd <= 1'b0;
        #1 d = swRdata;
        @(posedge clk_sys);
    endtask
    // poll status until not busy
    task automatic waitIdle();
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < 500; i++) begin
            rd(`FBPE_OFS_STATUS, s);
            if (s[`FBPE_ST_BUSY] === 1'b0) return;
        end
        chkReg("busy", 0, 1);
    endtask
    // expect the two unlock writes
    task automatic unlock();
        exp.push_back({`FBPE_UNLOCK_A1, `FBPE_UNLOCK_D1});
        exp.push_back({`FBPE_UNLOCK_A2, `FBPE_UNLOCK_D2});
    endtask
    initial begin
        void'($urandom(69302));
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        rd(`FBPE_OFS_STATUS, s);
        chkReg("status after reset", 0, s);
        rd(8'h14, s);
        chkReg("unmapped", 0, s);
        // buffer programs: full page, single last word, random
        for (int r = 0; r < 4; r++) begin
            n = (r == 0) ? 32 : (r == 1) ? 1 : $urandom_range(1, 32);
            k = (r == 1) ? 31 : $urandom_range(0, 32 - n);
            t = 24'({$urandom_range(0, 16'hffff), 5'h00}) + k[23:0];
            wr(`FBPE_OFS_COUNT, n - 1);
            w.delete();
            for (int i = 0; i < n; i++) begin
                w.push_back(16'($urandom()));
                wr(`FBPE_OFS_DATA, {16'h0, w[i]});
            end
            wr(`FBPE_OFS_ADDR, t);
            wr(`FBPE_OFS_CTRL, 32'h1);
            waitIdle();
            unlock();
            exp.push_back({t, `FBPE_CMD_LOAD});
            exp.push_back({t, 16'(n - 1)});
            foreach (w[i]) exp.push_back({t + 24'(i), w[i]});
            exp.push_back({t, `FBPE_CMD_CONFIRM});
            chkSeq();
            chkReg("done", 1, s[`FBPE_ST_DONE]);
            chkReg("poll word", {(t[15:0] + 16'(n - 1)) ^ 16'h5a5a, 16'h8},
                s & 32'hffff_000c);
        end
        // page crossing load is refused
        wr(`FBPE_OFS_COUNT, 5);
        wr(`FBPE_OFS_ADDR, 24'h00101e);
        wr(`FBPE_OFS_CTRL, 32'h1);
        repeat (3) @(posedge clk_sys);
        rd(`FBPE_OFS_STATUS, s);
        chkReg("page error", 1, s[`FBPE_ST_PAGEERR]);
        chkSeq();
        // sector erase with one added sector inside the window
        t = 24'($urandom());
        t2 = 24'($urandom());
        wr(`FBPE_OFS_ADDR, t);
        wr(`FBPE_OFS_CTRL, 32'h2);
        for (int i = 0; i < 200 && s[`FBPE_ST_WINDOW] !== 1'b1; i++)
            rd(`FBPE_OFS_STATUS, s);
        chkReg("in window", 1, s[`FBPE_ST_WINDOW]);
        wr(`FBPE_OFS_ADDR, t2);
        wr(`FBPE_OFS_CTRL, 32'h10);
        waitIdle();
        unlock();
        exp.push_back({`FBPE_UNLOCK_A1, `FBPE_CMD_SETUP});
        unlock();
        exp.push_back({t, `FBPE_CMD_SECTOR});
        exp.push_back({t2, `FBPE_CMD_SECTOR});
        chkSeq();
        // chip erase then abort reset
        for (int op = 0; op < 2; op++) begin
            wr(`FBPE_OFS_CTRL, op ? 32'h8 : 32'h4);
            waitIdle();
            unlock();
            if (op == 0) begin
                exp.push_back({`FBPE_UNLOCK_A1, `FBPE_CMD_SETUP});
                unlock();
            end
            exp.push_back({`FBPE_UNLOCK_A1,
                op ? `FBPE_CMD_ABORTRST : `FBPE_CMD_CHIP});
            chkSeq();
        end
        // hardware reset during a chip erase
        wr(`FBPE_OFS_CTRL, 32'h4);
        repeat (40) @(posedge clk_sys);
        chkReg("erase running", 1, flash.busy);
        wr(`FBPE_OFS_CTRL, 32'h20);
        // the first low cycle passes inside the write task
        k = 1;
        #1;
        while (pins.rstN === 1'b0 && k < 100) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        chkReg("reset pulse", `FBPE_RST_CYC, k);
        chkReg("erase stopped", 0, flash.busy);
        print_verdict();
    end
endmodule

// [rtl/fbpe_host.sv]
// host controller sequencing buffer program and erase on a nor flash
//
// The strobed register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "fbpe_params.svh"

module fbpe_host #(
    parameter int WIN_CYC = `FBPE_WIN_CYC, // sector add window
    parameter int WE_CYC = `FBPE_WE_CYC, // write strobe low time
    parameter int RD_CYC = `FBPE_RD_CYC, // read access time
    parameter int RST_CYC = `FBPE_RST_CYC, // reset pulse length
    parameter int BUF_WORDS = 32 // write buffer depth
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire fbpe_pkg::fbpe_swreq_t swReq,
    output logic [31:0] swRdata,
    output fbpe_pkg::fbpe_pins_t flashPins,
    input wire logic [15:0] flashDqIn
);
    import fbpe_pkg::*;

    // controller state
    fbpe_state_t stateReg, stateNext;
    fbpe_op_t opReg, opNext;
    logic [5:0] stepReg, stepNext; // write cycle index within sequence
    logic [4:0] cntReg, cntNext; // words minus one
    logic [23:0] tgtReg, tgtNext; // program or sector address
    logic [4:0] fillReg, fillNext; // buffer load index
    logic [15:0] timerReg, timerNext; // phase and window counter
    logic [15:0] rdReg, rdNext; // last polled word
    logic prevTglReg, prevTglNext; // toggle bit of previous poll
    logic havePrevReg, havePrevNext; // a previous poll exists
    logic pageErrReg, pageErrNext; // sticky page fault
    logic doneReg, doneNext; // sticky completion
    logic [31:0] rdataReg, rdataNext; // software read data
    fbpe_pins_t pinsReg, pinsNext;

    logic [15:0] bufMem [BUF_WORDS];
    // three stage pin synchroniser
    logic [15:0] dqS1, dqS2, dqS3;
    // decoded software strobes
    logic ctrlWr;
    logic [5:0] dataIdx;
    fbpe_cyc_t cyc;

    // last write step of each sequence
    function automatic logic [5:0] lastStep(fbpe_op_t op, logic [4:0] cnt);
        case (op)
            OP_BUF: lastStep = 6'({1'b0, cnt}) + 6'h05;
            OP_SECT, OP_CHIP: lastStep = 6'h05;
            OP_ABORT: lastStep = 6'h02;
            default: lastStep = 6'h00;
        endcase
    endfunction

    // address and data of one write cycle
    function automatic fbpe_cyc_t cycleFor(fbpe_op_t op, logic [5:0] step,
        logic [23:0] tgt, logic [4:0] cnt, logic [15:0] word);
        fbpe_cyc_t c;
        c.addr = tgt;
        c.data = `FBPE_CMD_SECTOR;
        if (op == OP_ADD) begin
            // single extra sector write
            c.data = `FBPE_CMD_SECTOR;
        end else if (step == 6'h00 || (op != OP_BUF && step == 6'h03)) begin
            c.addr = `FBPE_UNLOCK_A1;
            c.data = `FBPE_UNLOCK_D1;
        end else if (step == 6'h01 || (op != OP_BUF && step == 6'h04)) begin
            c.addr = `FBPE_UNLOCK_A2;
            c.data = `FBPE_UNLOCK_D2;
        end else if (op == OP_BUF) begin
            if (step == 6'h02) begin
                c.data = `FBPE_CMD_LOAD;
            end else if (step == 6'h03) begin
                c.data = {11'h000, cnt};
            end else if (step == lastStep(op, cnt)) begin
                c.data = `FBPE_CMD_CONFIRM;
            end else begin
                // one pair per word, same page
                c.addr = tgt + 24'(step - 6'h04);
                c.data = word;
            end
        end else if (op == OP_ABORT) begin
            c.addr = `FBPE_UNLOCK_A1;
            c.data = `FBPE_CMD_ABORTRST;
        end else if (step == 6'h02) begin
            c.addr = `FBPE_UNLOCK_A1;
            c.data = `FBPE_CMD_SETUP;
        end else if (op == OP_CHIP) begin
            c.addr = `FBPE_UNLOCK_A1;
            c.data = `FBPE_CMD_CHIP;
        end
        return c;
    endfunction

    // software decode
    assign ctrlWr = swReq.wr && swReq.addr == `FBPE_OFS_CTRL;
    assign dataIdx = stepReg - 6'h04;
    assign cyc = cycleFor(opReg, stepReg, tgtReg, cntReg,
        bufMem[dataIdx[4:0]]);
    assign flashPins = pinsReg;
    assign swRdata = rdataReg;

    // buffer memory load, only while idle
    always_ff @(posedge clk_sys) begin
        if (swReq.wr && swReq.addr == `FBPE_OFS_DATA && stateReg == S_IDLE) begin
            bufMem[fillReg] <= swReq.wdata[15:0];
        end
    end

    // data bus synchroniser
    always_ff @(posedge clk_sys) begin
        dqS1 <= flashDqIn;
        dqS2 <= dqS1;
        dqS3 <= dqS2;
    end

    // next state of the sequencer and register file
    always_comb begin
        stateNext = stateReg;
        opNext = opReg;
        stepNext = stepReg;
        cntNext = cntReg;
        tgtNext = tgtReg;
        fillNext = fillReg;
        timerNext = timerReg;
        rdNext = rdReg;
        prevTglNext = prevTglReg;
        havePrevNext = havePrevReg;
        pageErrNext = pageErrReg;
        doneNext = doneReg;
        pinsNext = pinsReg;
        rdataNext = 32'h0000_0000;
        // address and count writable while idle or in window
        if (swReq.wr && (stateReg == S_IDLE || stateReg == S_WINDOW)) begin
            if (swReq.addr == `FBPE_OFS_ADDR) begin
                tgtNext = swReq.wdata[23:0];
            end
            if (swReq.addr == `FBPE_OFS_COUNT) begin
                cntNext = swReq.wdata[4:0];
                fillNext = 5'h00;
            end
        end
        // buffer fill index advances per data write
        if (swReq.wr && swReq.addr == `FBPE_OFS_DATA && stateReg == S_IDLE) begin
            fillNext = fillReg + 5'h01;
        end
        // register reads, data one cycle later
        if (swReq.rd) begin
            case (swReq.addr)
                `FBPE_OFS_ADDR: rdataNext = {8'h00, tgtReg};
                `FBPE_OFS_COUNT: rdataNext = {27'h0, cntReg};
                `FBPE_OFS_DATA: rdataNext = {27'h0, fillReg};
                `FBPE_OFS_STATUS: begin
                    rdataNext = {rdReg, 12'h000, doneReg, pageErrReg,
                        stateReg == S_WINDOW, stateReg != S_IDLE};
                end
                default: rdataNext = 32'h0000_0000;
            endcase
        end
        case (stateReg)
            // idle: pins released, accept a new order
            S_IDLE: begin
                if (ctrlWr) begin
                    stepNext = 6'h00;
                    timerNext = 16'h0000;
                    if (swReq.wdata[`FBPE_CTRL_PROG]) begin
                        // refuse a load that crosses a page
                        if ({1'b0, tgtReg[4:0]} + {1'b0, cntReg} >
                            `FBPE_PAGE_LAST) begin
                            pageErrNext = 1'b1;
                        end else begin
                            pageErrNext = 1'b0;
                            doneNext = 1'b0;
                            opNext = OP_BUF;
                            stateNext = S_SETUP;
                        end
                    end else if (swReq.wdata[`FBPE_CTRL_SECT]) begin
                        opNext = OP_SECT;
                        doneNext = 1'b0;
                        stateNext = S_SETUP;
                    end else if (swReq.wdata[`FBPE_CTRL_CHIP]) begin
                        opNext = OP_CHIP;
                        doneNext = 1'b0;
                        stateNext = S_SETUP;
                    end else if (swReq.wdata[`FBPE_CTRL_ABORT]) begin
                        opNext = OP_ABORT;
                        doneNext = 1'b0;
                        stateNext = S_SETUP;
                    end
                end
            end
            // present address and data
            S_SETUP: begin
                pinsNext.addr = cyc.addr;
                pinsNext.dout = cyc.data;
                pinsNext.dqOe = 1'b1;
                pinsNext.ceN = 1'b0;
                timerNext = 16'h0000;
                stateNext = S_WELOW;
            end
            // write strobe low
            S_WELOW: begin
                pinsNext.weN = 1'b0;
                timerNext = timerReg + 16'h0001;
                // low for WE_CYC whole cycles
                if (timerReg == 16'(WE_CYC)) begin
                    pinsNext.weN = 1'b1;
                    stateNext = S_HOLD;
                end
            end
            // strobe has risen, hold then advance
            S_HOLD: begin
                pinsNext.dqOe = 1'b0;
                pinsNext.ceN = 1'b1;
                timerNext = 16'h0000;
                havePrevNext = 1'b0;
                if (opReg != OP_ADD && stepReg != lastStep(opReg, cntReg)) begin
                    stepNext = stepReg + 6'h01;
                    stateNext = S_SETUP;
                end else if (opReg == OP_SECT || opReg == OP_ADD) begin
                    // window counted from the rising strobe
                    stateNext = S_WINDOW;
                end else if (opReg == OP_ABORT) begin
                    doneNext = 1'b1;
                    stateNext = S_IDLE;
                end else begin
                    stateNext = S_RDLOW;
                end
            end
            // sector add window
            S_WINDOW: begin
                timerNext = timerReg + 16'h0001;
                if (ctrlWr && swReq.wdata[`FBPE_CTRL_ADD] &&
                    timerReg < 16'(WIN_CYC - 1)) begin
                    // extra sector only inside the window
                    opNext = OP_ADD;
                    stateNext = S_SETUP;
                end else if (timerReg >= 16'(WIN_CYC - 1)) begin
                    timerNext = 16'h0000;
                    stateNext = S_RDLOW;
                end
            end
            // status read of the busy location
            S_RDLOW: begin
                pinsNext.addr = (opReg == OP_BUF) ?
                    tgtReg + 24'(cntReg) : tgtReg;
                pinsNext.ceN = 1'b0;
                pinsNext.oeN = 1'b0;
                timerNext = timerReg + 16'h0001;
                if (timerReg >= 16'(RD_CYC + 2) && dqS2 == dqS3) begin
                    rdNext = dqS3;
                    stateNext = S_RDEND;
                end
            end
            // end of read, finished when toggle stands still
            S_RDEND: begin
                pinsNext.ceN = 1'b1;
                pinsNext.oeN = 1'b1;
                timerNext = 16'h0000;
                prevTglNext = rdReg[`FBPE_TOGGLE_BIT];
                havePrevNext = 1'b1;
                if (havePrevReg && prevTglReg == rdReg[`FBPE_TOGGLE_BIT]) begin
                    doneNext = 1'b1;
                    stateNext = S_IDLE;
                end else begin
                    stateNext = S_RDLOW;
                end
            end
            // hardware reset pulse
            S_RST: begin
                pinsNext.rstN = 1'b0;
                timerNext = timerReg + 16'h0001;
                if (timerReg == 16'(RST_CYC - 1)) begin
                    pinsNext.rstN = 1'b1;
                    stateNext = S_IDLE;
                end
            end
            default: stateNext = S_IDLE;
        endcase
        if (ctrlWr && swReq.wdata[`FBPE_CTRL_HWRST]) begin
            pinsNext = '{addr: 24'h0, dout: 16'h0, dqOe: 1'b0, ceN: 1'b1,
                weN: 1'b1, oeN: 1'b1, rstN: 1'b0};
            timerNext = 16'h0000;
            doneNext = 1'b0;
            stateNext = S_RST;
        end
    end

    // register all sequencer state
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stateReg <= S_IDLE;
            opReg <= OP_BUF;
            stepReg <= 6'h00;
            cntReg <= 5'h00;
            tgtReg <= 24'h000000;
            fillReg <= 5'h00;
            timerReg <= 16'h0000;
            rdReg <= 16'h0000;
            prevTglReg <= 1'b0;
            havePrevReg <= 1'b0;
            pageErrReg <= 1'b0;
            doneReg <= 1'b0;
            rdataReg <= 32'h0000_0000;
            pinsReg <= '{addr: 24'h0, dout: 16'h0, dqOe: 1'b0, ceN: 1'b1,
                weN: 1'b1, oeN: 1'b1, rstN: 1'b1};
        end else begin
            stateReg <= stateNext;
            opReg <= opNext;
            stepReg <= stepNext;
            cntReg <= cntNext;
            tgtReg <= tgtNext;
            fillReg <= fillNext;
            timerReg <= timerNext;
            rdReg <= rdNext;
            prevTglReg <= prevTglNext;
            havePrevReg <= havePrevNext;
            pageErrReg <= pageErrNext;
            doneReg <= doneNext;
            rdataReg <= rdataNext;
            pinsReg <= pinsNext;
        end
    end

    // checks on the driven flash cycles
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    AST_UNLOCK_FIRST: assert property (
        $fell(pinsReg.weN) && stepReg == 6'h00 && opReg != OP_ADD |->
        pinsReg.addr == `FBPE_UNLOCK_A1 && pinsReg.dout == `FBPE_UNLOCK_D1)
        else $error("first unlock cycle wrong");
    AST_UNLOCK_SECOND: assert property (
        $fell(pinsReg.weN) && stepReg == 6'h01 |->
        pinsReg.addr == `FBPE_UNLOCK_A2 && pinsReg.dout == `FBPE_UNLOCK_D2)
        else $error("second unlock cycle wrong");
    AST_LOAD_CMD: assert property (
        $fell(pinsReg.weN) && opReg == OP_BUF && stepReg == 6'h02 |->
        pinsReg.addr == tgtReg && pinsReg.dout == `FBPE_CMD_LOAD)
        else $error("buffer load command wrong");
    AST_WORD_COUNT: assert property (
        $fell(pinsReg.weN) && opReg == OP_BUF && stepReg == 6'h03 |->
        pinsReg.dout == {11'h000, cntReg})
        else $error("word count write wrong");
    AST_CONFIRM: assert property (
        opReg == OP_BUF && stepReg == 6'({1'b0, cntReg}) + 6'h05 &&
        $fell(pinsReg.weN) |-> pinsReg.dout == `FBPE_CMD_CONFIRM
        ##[1:8] stateReg == S_RDLOW)
        else $error("confirm missing or poll not started");
    AST_SAME_PAGE: assert property (
        $fell(pinsReg.weN) && opReg == OP_BUF && stepReg > 6'h03 |->
        pinsReg.addr[23:5] == tgtReg[23:5])
        else $error("buffered word outside page");
    AST_ABORT_RESET: assert property (
        $fell(pinsReg.weN) && opReg == OP_ABORT && stepReg == 6'h02 |->
        pinsReg.addr == `FBPE_UNLOCK_A1 && pinsReg.dout == `FBPE_CMD_ABORTRST)
        else $error("abort reset word wrong");
    AST_ERASE_SETUP: assert property (
        $fell(pinsReg.weN) && (opReg == OP_SECT || opReg == OP_CHIP) &&
        stepReg == 6'h02 |-> pinsReg.dout == `FBPE_CMD_SETUP)
        else $error("erase setup word wrong");
    AST_CHIP_LAST: assert property (
        $fell(pinsReg.weN) && opReg == OP_CHIP && stepReg == 6'h05 |->
        pinsReg.addr == `FBPE_UNLOCK_A1 && pinsReg.dout == `FBPE_CMD_CHIP)
        else $error("chip erase command wrong");
    AST_ADD_IN_WINDOW: assert property (
        stateReg == S_WINDOW && stateNext == S_SETUP |->
        timerReg < 16'(WIN_CYC - 1) ##3 !pinsReg.weN)
        else $error("sector add outside window");
    AST_HW_RESET: assert property (
        $fell(pinsReg.rstN) |-> stateReg == S_RST && pinsReg.weN &&
        !pinsReg.dqOe)
        else $error("reset pulse with bus active");
endmodule

// [rtl/fbpe_params.svh]
// offsets, command words, field positions and timing counts
`ifndef FBPE_PARAMS_SVH
`define FBPE_PARAMS_SVH

// software register offsets
`define FBPE_OFS_CTRL 8'h00
`define FBPE_OFS_ADDR 8'h04
`define FBPE_OFS_COUNT 8'h08
`define FBPE_OFS_DATA 8'h0c
`define FBPE_OFS_STATUS 8'h10

// control register bit positions
`define FBPE_CTRL_PROG 0
`define FBPE_CTRL_SECT 1
`define FBPE_CTRL_CHIP 2
`define FBPE_CTRL_ABORT 3
`define FBPE_CTRL_ADD 4
`define FBPE_CTRL_HWRST 5

// status register bit positions
`define FBPE_ST_BUSY 0
`define FBPE_ST_WINDOW 1
`define FBPE_ST_PAGEERR 2
`define FBPE_ST_DONE 3
`define FBPE_ST_RDLSB 16

// flash word addresses and command data
`define FBPE_UNLOCK_A1 24'h000555
`define FBPE_UNLOCK_A2 24'h0002aa
`define FBPE_UNLOCK_D1 16'h00aa
`define FBPE_UNLOCK_D2 16'h0055
`define FBPE_CMD_LOAD 16'h0025
`define FBPE_CMD_CONFIRM 16'h0029
`define FBPE_CMD_ABORTRST 16'h00f0
`define FBPE_CMD_SETUP 16'h0080
`define FBPE_CMD_SECTOR 16'h0030
`define FBPE_CMD_CHIP 16'h0010
`define FBPE_PAGE_LAST 6'h1f
`define FBPE_TOGGLE_BIT 6
`define FBPE_WINEXP_BIT 3

// timing: figures in their own unit, counts derived from the clock
`define FBPE_CLK_NS 25
`define FBPE_WE_LOW_NS 35
`define FBPE_RD_NS 70
`define FBPE_RST_NS 500
`define FBPE_WIN_US 50
`define FBPE_WE_CYC ((`FBPE_WE_LOW_NS + `FBPE_CLK_NS - 1) / `FBPE_CLK_NS)
`define FBPE_RD_CYC ((`FBPE_RD_NS + `FBPE_CLK_NS - 1) / `FBPE_CLK_NS)
`define FBPE_RST_CYC ((`FBPE_RST_NS + `FBPE_CLK_NS - 1) / `FBPE_CLK_NS)
`define FBPE_WIN_CYC ((`FBPE_WIN_US * 1000) / `FBPE_CLK_NS)

`endif

// [rtl/fbpe_pkg.sv]
// types shared by the flash sequencer controller
package fbpe_pkg;

    // operation being sequenced
    typedef enum logic [2:0] {
        OP_BUF, OP_SECT, OP_CHIP, OP_ABORT, OP_ADD
    } fbpe_op_t;

    // controller states
    typedef enum logic [3:0] {
        S_IDLE, S_SETUP, S_WELOW, S_HOLD, S_WINDOW,
        S_RDLOW, S_RDEND, S_RST
    } fbpe_state_t;

    // flash pin outputs
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] dout;
        logic dqOe;
        logic ceN;
        logic weN;
        logic oeN;
        logic rstN;
    } fbpe_pins_t;

    // software register request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } fbpe_swreq_t;

    // one flash bus write cycle
    typedef struct packed {
        logic [23:0] addr;
        logic [15:0] data;
    } fbpe_cyc_t;

endpackage
